// >>> verilog/eeprom_nvm_pkg.sv
package eeprom_nvm_pkg;

  // bus geometry
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int ARRAY_AW    = 9;
  localparam int ARRAY_BYTES = 512;

  // register and array addresses on the plain register port
  localparam logic [15:0] CTRL_ADDR  = 16'h0020;
  localparam logic [15:0] ACR_ADDR   = 16'h0021;
  localparam logic [15:0] NVR_ADDR   = 16'h0022;
  localparam logic [15:0] ARRAY_BASE = 16'h0600;
  localparam int          ARRAY_TAG_LSB = 9;

  // top sixteen bytes of the second block, as offset bits [8:4]
  localparam logic [4:0] SECURE_ROW = 5'h0f;

  // reset and fill values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] NVR_FACTORY = 8'hf0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam logic [8:0] BLOCK_LAST  = 9'h07f;
  localparam logic [8:0] ARRAY_LAST  = 9'h1ff;

  // timing: times in microseconds, counts derived at the clock rate
  localparam int CLK_MHZ            = 100;
  localparam int PROG_TIME_US       = 10000;
  localparam int BYTE_ERASE_TIME_US = 10000;
  localparam int BLOCK_ERASE_TIME_US = 10000;
  localparam int BULK_ERASE_TIME_US = 10000;
  localparam int PROG_CYCLES        = PROG_TIME_US * CLK_MHZ;
  localparam int BYTE_ERASE_CYCLES  = BYTE_ERASE_TIME_US * CLK_MHZ;
  localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int BULK_ERASE_CYCLES  = BULK_ERASE_TIME_US * CLK_MHZ;
  localparam int AUTO_TRIM_SHIFT    = 3;

  typedef enum logic [1:0] {
    MODE_BYTE_PROG   = 2'b00,
    MODE_BYTE_ERASE  = 2'b01,
    MODE_BLOCK_ERASE = 2'b10,
    MODE_BULK_ERASE  = 2'b11
  } erase_mode_e;

  // nvm_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic        spare;
    logic        array_power_down;
    erase_mode_e erase_mode;
    logic        bus_latch_enable;
    logic        auto_term;
    logic        reserved;
    logic        hv_pump_enable;
  } ctrl_s;

  // array_config / nonvolatile_config layout
  typedef struct packed {
    logic [2:0] spare;
    logic       security_arm;
    logic [3:0] block_guard_bits;
  } acr_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_s;

endpackage

// >>> verilog/eeprom_nvm_ctrl.sv
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
// Contract
// - erase sets bits, only unprotected bytes
// - mode codes decoded; guarded block refuses
// - auto timer clears pump enable itself
// - latch captures array and nonvolatile writes and reads
// - while latching, control writes wait for a capture
// - latest valid write replaces earlier capture
// - latched array read returns data, captures address
// - refuse pump without latch and capture
// - latch cannot clear while pump set
// - power down bit disables array
// - control bit 7 stored, no effect
// - pump needs latch and a captured access
// - mode and latch bits reset clear
// - config loaded from nonvolatile at reset
// - security bit write once, active low
// - four guard bits protect 128-byte blocks
// - nonvolatile byte programmed like array byte
// - nonvolatile byte ships as f0
// - secured: block and bulk erase refused
// - secured: top row and config frozen
// - guard bits reload on nonvolatile read
module eeprom_nvm_ctrl #(
  parameter int unsigned PROG_CYCLES  = eeprom_nvm_pkg::PROG_CYCLES,
  parameter int unsigned BYTE_CYCLES  = eeprom_nvm_pkg::BYTE_ERASE_CYCLES,
  parameter int unsigned BLOCK_CYCLES = eeprom_nvm_pkg::BLOCK_ERASE_CYCLES,
  parameter int unsigned BULK_CYCLES  = eeprom_nvm_pkg::BULK_ERASE_CYCLES
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire eeprom_nvm_pkg::bus_req_s  bus_req,
  output logic [eeprom_nvm_pkg::DATA_W-1:0] rd_data,
  output logic                           hv_pump_on,
  output logic                           array_disabled,
  output logic                           op_busy
);
  import eeprom_nvm_pkg::*;

  // the timer trims counts by one eighth, so tiny values cannot work
  if (PROG_CYCLES < 8 || BYTE_CYCLES < 8 || BLOCK_CYCLES < 8 ||
      BULK_CYCLES < 8) begin : g_bad_cycles
    $error("cycle counts must be at least 8");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SWEEP, ST_DONE} op_state_e;

  logic [DATA_W-1:0]   mem [ARRAY_BYTES];
  acr_s                nvr_reg = acr_s'(NVR_FACTORY);
  ctrl_s               ctrl_reg;
  acr_s                acr_reg;
  logic [ARRAY_AW-1:0] cap_off_reg;
  logic                cap_nvr_reg;
  logic [DATA_W-1:0]   cap_data_reg;
  logic                cap_valid_reg;
  op_state_e           state_reg;
  logic [31:0]         timer_reg;
  logic [ARRAY_AW-1:0] sweep_reg;
  logic [ARRAY_AW-1:0] sweep_end_reg;
  erase_mode_e         op_mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_array(input logic [ADDR_W-1:0] a);
    is_array = a[ADDR_W-1:ARRAY_TAG_LSB] ==
               ARRAY_BASE[ADDR_W-1:ARRAY_TAG_LSB];
  endfunction

  // may this mode run on this target with this configuration
  function automatic logic op_allowed(input erase_mode_e m,
                                      input logic [ARRAY_AW-1:0] off,
                                      input logic nvr,
                                      input acr_s a);
    logic secured;
    secured = !a.security_arm;
    if (nvr)
      op_allowed = !secured;
    else if (secured && (m == MODE_BLOCK_ERASE || m == MODE_BULK_ERASE))
      op_allowed = 1'b0;
    else if (secured && off[8:4] == SECURE_ROW)
      op_allowed = 1'b0;
    else if (m == MODE_BULK_ERASE)
      op_allowed = 1'b1; // guarded blocks are skipped by the sweep
    else
      op_allowed = !a.block_guard_bits[off[8:7]];
  endfunction

  // auto termination runs one eighth short of the nominal time
  function automatic logic [31:0] op_cycles(input erase_mode_e m,
                                            input logic auto_on);
    logic [31:0] c;
    unique case (m)
      MODE_BYTE_PROG:   c = 32'(PROG_CYCLES);
      MODE_BYTE_ERASE:  c = 32'(BYTE_CYCLES);
      MODE_BLOCK_ERASE: c = 32'(BLOCK_CYCLES);
      MODE_BULK_ERASE:  c = 32'(BULK_CYCLES);
    endcase
    op_cycles = auto_on ? c - (c >> AUTO_TRIM_SHIFT) : c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  ctrl_s               ctrl_wr;
  logic                wr_ctrl;
  logic                hit_arr;
  logic                hit_nvr;
  logic                acc_nvm;
  logic                rd_nvm;
  logic [ARRAY_AW-1:0] bus_off;
  logic                ctrl_locked;
  logic                pump_ok;

  assign ctrl_wr  = ctrl_s'(bus_req.wdata);
  assign wr_ctrl  = bus_req.wr && bus_req.addr == CTRL_ADDR;
  assign hit_arr  = is_array(bus_req.addr);
  assign hit_nvr  = bus_req.addr == NVR_ADDR;
  assign acc_nvm  = (bus_req.wr || bus_req.rd) && (hit_arr || hit_nvr);
  assign rd_nvm   = bus_req.rd && (hit_arr || hit_nvr);
  assign bus_off  = bus_req.addr[ARRAY_AW-1:0];
  // once latching, control writes wait until a target was captured
  assign ctrl_locked = ctrl_reg.bus_latch_enable && !cap_valid_reg;
  assign pump_ok = ctrl_reg.bus_latch_enable && cap_valid_reg &&
                   !ctrl_reg.array_power_down && state_reg == ST_IDLE &&
                   op_allowed(ctrl_wr.erase_mode, cap_off_reg, cap_nvr_reg,
                              acr_reg);

  ////////////////////////////////////////////////////////////////////////////
  // nvm_control register

  // the timer's clear beats a software write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= ctrl_s'(CTRL_RESET);
    end else if (state_reg == ST_DONE && ctrl_reg.auto_term) begin
      ctrl_reg.hv_pump_enable <= 1'b0;
    end else if (wr_ctrl && !ctrl_locked) begin
      ctrl_reg.spare            <= ctrl_wr.spare;
      ctrl_reg.array_power_down <= ctrl_wr.array_power_down;
      ctrl_reg.erase_mode       <= ctrl_wr.erase_mode;
      ctrl_reg.auto_term        <= ctrl_wr.auto_term;
      ctrl_reg.reserved         <= ctrl_wr.reserved;
      // latch stays while the pump is on, giving the voltage time to fall
      ctrl_reg.bus_latch_enable <= ctrl_reg.hv_pump_enable ||
                                   ctrl_wr.bus_latch_enable;
      ctrl_reg.hv_pump_enable   <= ctrl_wr.hv_pump_enable &&
                                   (ctrl_reg.hv_pump_enable || pump_ok);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and data capture

  // frozen while the pump runs, so the target cannot move mid-cycle
  always_ff @(posedge ref_clk) begin
    if (reset || !ctrl_reg.bus_latch_enable) begin
      cap_valid_reg <= 1'b0;
      cap_off_reg   <= '0;
      cap_nvr_reg   <= 1'b0;
      cap_data_reg  <= '0;
    end else if (acc_nvm && !ctrl_reg.hv_pump_enable &&
                 !ctrl_reg.array_power_down) begin
      cap_valid_reg <= 1'b1;
      cap_off_reg   <= bus_off;
      cap_nvr_reg   <= hit_nvr;
      if (bus_req.wr)
        cap_data_reg <= bus_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array_config register

  // security only ever moves towards enabled until the next reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acr_reg <= nvr_reg;
    end else begin
      if (bus_req.rd && hit_nvr) begin
        acr_reg.block_guard_bits <= nvr_reg.block_guard_bits;
        acr_reg.security_arm <= acr_reg.security_arm &&
                                nvr_reg.security_arm;
      end
      if (bus_req.wr && bus_req.addr == ACR_ADDR)
        acr_reg.spare <= bus_req.wdata[7:5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program/erase sequencer

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      timer_reg     <= '0;
      sweep_reg     <= '0;
      sweep_end_reg <= '0;
      op_mode_reg   <= MODE_BYTE_PROG;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (ctrl_reg.hv_pump_enable) begin
            state_reg   <= ST_RUN;
            op_mode_reg <= ctrl_reg.erase_mode;
            timer_reg   <= op_cycles(ctrl_reg.erase_mode,
                                     ctrl_reg.auto_term) - 32'd1;
            unique case (ctrl_reg.erase_mode)
              MODE_BLOCK_ERASE: begin
                sweep_reg     <= {cap_off_reg[8:7], 7'h00};
                sweep_end_reg <= {cap_off_reg[8:7], 7'h00} | BLOCK_LAST;
              end
              MODE_BULK_ERASE: begin
                sweep_reg     <= '0;
                sweep_end_reg <= ARRAY_LAST;
              end
              default: begin
                sweep_reg     <= cap_off_reg;
                sweep_end_reg <= cap_off_reg;
              end
            endcase
          end
        end
        ST_RUN: begin
          // software stopping early leaves the array untouched
          if (!ctrl_reg.hv_pump_enable)
            state_reg <= ST_IDLE;
          else if (rd_nvm)
            state_reg <= ST_DONE;
          else if (timer_reg == 32'd0)
            state_reg <= ST_SWEEP;
          else
            timer_reg <= timer_reg - 32'd1;
        end
        ST_SWEEP: begin
          if (sweep_reg == sweep_end_reg || cap_nvr_reg)
            state_reg <= ST_DONE;
          else
            sweep_reg <= sweep_reg + 9'd1;
        end
        ST_DONE: begin
          if (!ctrl_reg.hv_pump_enable)
            state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cell update, one byte per cycle; nonvolatile, so no reset

  logic sweep_guarded;
  assign sweep_guarded = acr_reg.block_guard_bits[sweep_reg[8:7]];

  always_ff @(posedge ref_clk) begin
    if (state_reg == ST_SWEEP) begin
      if (cap_nvr_reg) begin
        nvr_reg <= (op_mode_reg == MODE_BYTE_PROG) ?
                   nvr_reg & acr_s'(cap_data_reg) : acr_s'(ERASED_BYTE);
      end else if (!sweep_guarded) begin
        // programming only clears bits, erasing only sets them
        mem[sweep_reg] <= (op_mode_reg == MODE_BYTE_PROG) ?
                          mem[sweep_reg] & cap_data_reg : ERASED_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data valid only in the cycle after the strobe

  always_ff @(posedge ref_clk) begin
    if (reset || !bus_req.rd) begin
      rd_data <= '0;
    end else if (bus_req.addr == CTRL_ADDR) begin
      rd_data <= ctrl_reg;
    end else if (bus_req.addr == ACR_ADDR) begin
      rd_data <= acr_reg;
    end else if (hit_arr || hit_nvr) begin
      if (ctrl_reg.array_power_down)
        rd_data <= ERASED_BYTE;
      else if (ctrl_reg.bus_latch_enable && cap_valid_reg)
        rd_data <= cap_data_reg;
      else if (hit_nvr)
        rd_data <= nvr_reg;
      else
        rd_data <= mem[bus_off];
    end else begin
      rd_data <= UNMAPPED_RD;
    end
  end

  assign hv_pump_on     = ctrl_reg.hv_pump_enable;
  assign array_disabled = ctrl_reg.array_power_down;
  assign op_busy        = state_reg != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  pump_needs_latch_a: assert property (
    hv_pump_on |-> ctrl_reg.bus_latch_enable && cap_valid_reg)
    else $error("pump on without latch and capture");

  pump_refused_a: assert property (
    wr_ctrl && ctrl_wr.hv_pump_enable && !hv_pump_on &&
    !(ctrl_reg.bus_latch_enable && cap_valid_reg) |=> !hv_pump_on)
    else $error("pump set without a captured target");

  latch_hold_a: assert property (
    $fell(ctrl_reg.bus_latch_enable) |-> !$past(hv_pump_on))
    else $error("latch cleared while pump was on");

  ctrl_locked_a: assert property (
    wr_ctrl && ctrl_locked && !(state_reg == ST_DONE) |=> $stable(ctrl_reg))
    else $error("control changed before a capture");

  capture_a: assert property (
    bus_req.wr && hit_arr && ctrl_reg.bus_latch_enable && !hv_pump_on &&
    !array_disabled |=> cap_valid_reg && cap_off_reg == $past(bus_off) &&
    cap_data_reg == $past(bus_req.wdata))
    else $error("valid array write not captured");

  latched_read_a: assert property (
    bus_req.rd && hit_arr && ctrl_reg.bus_latch_enable && cap_valid_reg &&
    !array_disabled |=> rd_data == $past(cap_data_reg))
    else $error("latched read returned wrong data");

  auto_clear_a: assert property (
    state_reg == ST_DONE && ctrl_reg.auto_term |=> !hv_pump_on ##1 !op_busy)
    else $error("auto mode did not end the cycle");

  guard_a: assert property (
    $rose(hv_pump_on) |-> op_allowed(ctrl_reg.erase_mode, cap_off_reg,
                                     cap_nvr_reg, acr_reg))
    else $error("pump enabled on a forbidden target");

  security_a: assert property (
    !acr_reg.security_arm |=> !acr_reg.security_arm)
    else $error("security was disabled again");

  spare_bit_a: assert property (
    wr_ctrl && !ctrl_locked && state_reg != ST_DONE |=>
    ctrl_reg.spare == $past(ctrl_wr.spare))
    else $error("spare control bit not stored");

endmodule // eeprom_nvm_ctrl

// >>> sim/cpu_model.sv
`timescale 1ns/10ps
// software side: one strobe per access, released at the taking edge
module cpu_model
  import eeprom_nvm_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic [7:0]               rd_data,
  output eeprom_nvm_pkg::bus_req_s      bus_req
);

  // idle bus from time zero so the first edge sees no strobe
  initial begin
    bus_req = '0;
  end

  // write: one cycle, dropped right after the edge that takes it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req <= '0;
    // let the edge's updates settle before the caller looks at outputs
    #1;
  endtask

  // read: data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    d = rd_data;
  endtask

endmodule // cpu_model

// >>> sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import eeprom_nvm_pkg::*;

  localparam int N = 64;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  bus_req_s   bus_req;
  logic [7:0] rd_data;
  logic       hv_pump_on;
  logic       array_disabled;
  logic       op_busy;
  logic [7:0] v;
  int         err_count = 0;
  int         n_compared = 0;

  ////////////////////////////////////////////////////////////
  // clock and instances; short timer counts keep the run brief
  always #5 ref_clk = ~ref_clk;

  cpu_model cpu (
    .ref_clk (ref_clk),
    .rd_data (rd_data),
    .bus_req (bus_req)
  );

  eeprom_nvm_ctrl #(
    .PROG_CYCLES  (N),
    .BYTE_CYCLES  (N),
    .BLOCK_CYCLES (N),
    .BULK_CYCLES  (N)
  ) uut (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .bus_req        (bus_req),
    .rd_data        (rd_data),
    .hv_pump_on     (hv_pump_on),
    .array_disabled (array_disabled),
    .op_busy        (op_busy)
  );

  ////////////////////////////////////////////////////////////
  // comparison, verdict and shared access sequences
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp,
                       input string what);
    cpu.rd(a, v);
    check(what, v, exp);
  endtask

  // arm the pump, then finish by timer poll or by software timing
  task automatic go(input logic [7:0] c, input logic ok);
    int i;
    i = 0;
    cpu.wr(CTRL_ADDR, c | 8'h01);
    check("pump on", {7'h00, hv_pump_on}, {7'h00, ok});
    if (!ok) begin
      cpu.wr(CTRL_ADDR, 8'h00);
    end else if (c[2]) begin
      // only the control byte is read while the pump runs
      do begin
        cpu.rd(CTRL_ADDR, v);
        i++;
      end while (v[0] !== 1'b0 && i < 600);
      if (i >= 600) begin
        err_count++;
        close_out();
      end
      cpu.wr(CTRL_ADDR, 8'h00);
    end else begin
      repeat (N + 8) @(posedge ref_clk);
      check("busy", {7'h00, op_busy}, 8'h01);
      cpu.wr(CTRL_ADDR, 8'h00);
      rdchk(CTRL_ADDR, 8'h08, "latch kept");
      cpu.wr(CTRL_ADDR, 8'h00);
    end
    rdchk(CTRL_ADDR, 8'h00, "ctrl idle");
  endtask

  // mode and latch, target write, then the pump
  task automatic op(input logic [7:0] c, input logic [15:0] a,
                    input logic [7:0] d, input logic ok);
    cpu.wr(CTRL_ADDR, c);
    cpu.wr(a, d);
    go(c, ok);
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    rdchk(CTRL_ADDR, CTRL_RESET, "ctrl reset");
    rdchk(ACR_ADDR, NVR_FACTORY, "acr reset");
    rdchk(NVR_ADDR, NVR_FACTORY, "nvr reset");
    rdchk(16'h0030, UNMAPPED_RD, "unmapped");
    cpu.wr(ACR_ADDR, 8'h0f);
    rdchk(ACR_ADDR, 8'h10, "acr spare");
    cpu.wr(ACR_ADDR, 8'hff);
    $display("test registers done");

    cpu.wr(CTRL_ADDR, 8'h83);
    rdchk(CTRL_ADDR, 8'h82, "no latch pump");
    cpu.wr(CTRL_ADDR, 8'h40);
    check("power down", {7'h00, array_disabled}, 8'h01);
    rdchk(16'h0600, ERASED_BYTE, "powered down read");
    cpu.wr(CTRL_ADDR, 8'h00);
    check("power up", {7'h00, array_disabled}, 8'h00);
    $display("test control done");

    op(8'h3c, 16'h0700, 8'h00, 1'b1);
    rdchk(16'h0600, ERASED_BYTE, "bulk lo");
    rdchk(16'h07ff, ERASED_BYTE, "bulk hi");
    $display("test bulk done");

    cpu.wr(CTRL_ADDR, 8'h0c);
    cpu.wr(CTRL_ADDR, 8'h0d);
    rdchk(CTRL_ADDR, 8'h0c, "ctrl held");
    cpu.wr(16'h0030, 8'h00);
    cpu.wr(CTRL_ADDR, 8'h0d);
    check("pump off", {7'h00, hv_pump_on}, 8'h00);
    cpu.wr(16'h0600, 8'h5a);
    cpu.wr(16'h0601, 8'ha5);
    rdchk(16'h0601, 8'ha5, "latched read");
    go(8'h0c, 1'b1);
    rdchk(16'h0600, ERASED_BYTE, "first dropped");
    rdchk(16'h0601, 8'ha5, "program");
    $display("test latch done");

    op(8'h18, 16'h0601, 8'h00, 1'b1);
    rdchk(16'h0601, ERASED_BYTE, "byte erase");
    op(8'h0c, 16'h0680, 8'h00, 1'b1);
    op(8'h0c, 16'h0700, 8'h3c, 1'b1);
    op(8'h2c, 16'h06c5, 8'h00, 1'b1);
    rdchk(16'h0680, ERASED_BYTE, "block in");
    rdchk(16'h0700, 8'h3c, "block out");
    $display("test erase modes done");

    // programming only clears bits, so the guard bit needs an erase first
    op(8'h1c, NVR_ADDR, 8'h00, 1'b1);
    op(8'h0c, NVR_ADDR, 8'hf1, 1'b1);
    rdchk(NVR_ADDR, 8'hf1, "nvr prog");
    rdchk(ACR_ADDR, 8'hf1, "guard load");
    op(8'h0c, 16'h0602, 8'h00, 1'b0);
    rdchk(16'h0602, ERASED_BYTE, "guarded");
    op(8'h1c, 16'h0700, 8'h00, 1'b1);
    $display("test guard done");

    op(8'h0c, NVR_ADDR, 8'he1, 1'b1);
    rdchk(NVR_ADDR, 8'he1, "nvr secure");
    rdchk(ACR_ADDR, 8'he1, "secured");
    op(8'h2c, 16'h0700, 8'h00, 1'b0);
    op(8'h3c, 16'h0700, 8'h00, 1'b0);
    op(8'h0c, 16'h06f0, 8'h00, 1'b0);
    op(8'h1c, NVR_ADDR, 8'h00, 1'b0);
    op(8'h0c, 16'h0700, 8'h0f, 1'b1);
    rdchk(16'h0700, 8'h0f, "secure byte");
    rdchk(16'h06f0, ERASED_BYTE, "secure row");
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    rdchk(ACR_ADDR, 8'he1, "reload");
    rdchk(CTRL_ADDR, CTRL_RESET, "ctrl again");
    $display("test security done");
    close_out();
  end

endmodule // tb_top
